/* File: rtl/smg_regs.vh */
`ifndef SMG_REGS_VH
`define SMG_REGS_VH
// Summary of operation
// - In marker sync mode sync goes high at the start of each burst, sweep or arb playback.
// - The invert setting reverses the polarity of the sync output.
// - In burst mode sync goes low at the marker cycle, legal 2 to total plus one, default 2.
// - The marker cycle compare acts only with burst enabled and marker sync mode selected.
// - A bad marker cycle written with burst on loads the burst midpoint, flagging a conflict.
// - In sweep sync goes low at the marker frequency, within start to stop, default 500 Hz.
// - The marker frequency compare acts only with sweep enabled and marker sync mode selected.
// - A bad marker frequency in sweep is clamped to the nearer limit and flags a conflict.
// - Arb playback drops sync at marker sample, legal 4 to length minus 3, default midpoint.
// - The marker sample is kept only for the single active arb, never for sequence entries.
// - Sample set only with arb and marker+fixed, carrier+burst/sweep or marker+modulation.

// Register byte offsets
`define SMG_CTRL_OFS 12'h000
`define SMG_STAT_OFS 12'h004
`define SMG_MASK_OFS 12'h008
`define SMG_CHSEL_OFS 12'h00C
`define SMG_CYC_OFS 12'h010
`define SMG_FREQ_OFS 12'h014
`define SMG_POINT_OFS 12'h018

// Control field positions
`define SMG_CTRL_MARKER_BIT 0
`define SMG_CTRL_INVERT_BIT 1
`define SMG_CTRL_BURST_BIT 2
`define SMG_CTRL_SWEEP_BIT 3
`define SMG_CTRL_ARB_BIT 4
`define SMG_CTRL_SEQ_BIT 5
`define SMG_CTRL_FIXED_BIT 6
`define SMG_CTRL_MOD_BIT 7

// Status field positions
`define SMG_STAT_CONFLICT_BIT 0
`define SMG_STAT_REJECT_BIT 1

// Reset values and range limits
`define SMG_CYC_RST 32'h00000002
`define SMG_FREQ_RST 32'h000001F4
`define SMG_MIN_CYC 32'h00000002
`define SMG_MIN_POINT 32'h00000004
`define SMG_POINT_TAIL 32'h00000003
`endif

/* File: rtl/smg_channel.v */
`include "smg_regs.vh"
// One channel of marker settings and compare logic
module smg_channel #(
    parameter W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire marker_mode,
    input wire invert,
    input wire burst_en,
    input wire sweep_en,
    input wire arb_sel,
    input wire seq_sel,
    input wire fixed_frequency,
    input wire mod_active,
    input wire carrier_sync_mode,
    input wire wr_cyc,
    input wire wr_freq,
    input wire wr_point,
    input wire [W-1:0] wdata,
    input wire [W-1:0] burst_cycle_total,
    input wire [W-1:0] sweep_start,
    input wire [W-1:0] sweep_stop,
    input wire [W-1:0] arb_length,
    input wire start_evt,
    input wire [W-1:0] cycle_count,
    input wire [W-1:0] sweep_freq,
    input wire [W-1:0] sample_index,
    input wire arb_new,
    output reg [W-1:0] mark_cycle,
    output reg [W-1:0] mark_freq,
    output reg [W-1:0] mark_point,
    output reg sync_out,
    output reg conflict,
    output reg reject
);
    reg level;
    wire [W-1:0] lo_f;
    wire [W-1:0] hi_f;
    wire [W-1:0] max_cyc;
    wire [W-1:0] max_pt;
    wire [W-1:0] mid_pt;
    wire pt_ok;
    wire hit;

    // Sweep may run downward, so order the limits first
    assign lo_f = (sweep_start < sweep_stop) ? sweep_start : sweep_stop;
    assign hi_f = (sweep_start < sweep_stop) ? sweep_stop : sweep_start;
    assign max_cyc = burst_cycle_total + 1'b1;
    assign max_pt = arb_length - `SMG_POINT_TAIL;
    assign mid_pt = arb_length >> 1;
    // Marker sample accepted only in these combinations
    assign pt_ok = arb_sel && !seq_sel && ((marker_mode && fixed_frequency)
        || (carrier_sync_mode && (burst_en || sweep_en))
        || (marker_mode && mod_active));

    // Settings writes with range checks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mark_cycle <= `SMG_CYC_RST;
            mark_freq <= `SMG_FREQ_RST;
            mark_point <= {W{1'b0}};
            conflict <= 1'b0;
            reject <= 1'b0;
        end else begin
            conflict <= 1'b0;
            reject <= 1'b0;
            if (wr_cyc) begin
                if (burst_en && (wdata < `SMG_MIN_CYC || wdata > max_cyc)) begin
                    mark_cycle <= (burst_cycle_total >> 1) + 1'b1;
                    conflict <= 1'b1;
                end else begin
                    mark_cycle <= wdata;
                end
            end
            if (wr_freq) begin
                if (sweep_en && wdata < lo_f) begin
                    mark_freq <= lo_f;
                    conflict <= 1'b1;
                end else if (sweep_en && wdata > hi_f) begin
                    mark_freq <= hi_f;
                    conflict <= 1'b1;
                end else begin
                    mark_freq <= wdata;
                end
            end
            // New arb selected: default to its midpoint
            if (arb_new) begin
                mark_point <= mid_pt;
            end else if (wr_point) begin
                if (!pt_ok) begin
                    reject <= 1'b1;
                end else if (wdata < `SMG_MIN_POINT || wdata > max_pt) begin
                    reject <= 1'b1;
                end else begin
                    mark_point <= wdata;
                end
            end
        end
    end

    // Low point of the current playback
    assign hit = (marker_mode && burst_en && cycle_count == mark_cycle)
        || (marker_mode && sweep_en && sweep_freq == mark_freq)
        || (arb_sel && !burst_en && !sweep_en && sample_index == mark_point);

    // Marker level, set on start, cleared on hit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            if (marker_mode && start_evt) begin
                level <= 1'b1;
            end else if (hit) begin
                level <= 1'b0;
            end
            sync_out <= (marker_mode && start_evt ? 1'b1 : (hit ? 1'b0 : level)) ^ invert;
        end
    end
endmodule // smg_channel

/* File: rtl/smg_top.v */
`include "smg_regs.vh"
// Sync marker generator with APB register access
module smg_top #(
    parameter NCH = 2,
    parameter W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NCH-1:0] start_evt,
    input wire [NCH-1:0] arb_new,
    input wire [NCH*W-1:0] cycle_count,
    input wire [NCH*W-1:0] sweep_freq,
    input wire [NCH*W-1:0] sample_index,
    input wire [NCH*W-1:0] burst_cycle_total,
    input wire [NCH*W-1:0] sweep_start,
    input wire [NCH*W-1:0] sweep_stop,
    input wire [NCH*W-1:0] arb_length,
    output reg [NCH-1:0] sync_out,
    output reg irq
);
    reg [7:0] ctrl [0:NCH-1];
    reg [7:0] chsel;
    reg [1:0] stat;
    reg [1:0] mask;
    reg [31:0] next_rdata;
    wire acc;
    wire wr;
    wire [NCH-1:0] ch_conf;
    wire [NCH-1:0] ch_rej;
    wire [NCH-1:0] ch_sync;
    wire [NCH*W-1:0] ch_cyc;
    wire [NCH*W-1:0] ch_freq;
    wire [NCH*W-1:0] ch_pt;
    wire [7:0] cur_ctrl;
    wire [1:0] evt;
    integer i;

    assign acc = psel && penable;
    assign wr = acc && pwrite && !pready;
    assign cur_ctrl = ctrl[chsel[0]];
    assign evt = {|ch_rej, |ch_conf};

    // One channel instance each, all settings separate
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gch
            smg_channel #(.W(W)) u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .marker_mode(ctrl[g][`SMG_CTRL_MARKER_BIT]),
                .invert(ctrl[g][`SMG_CTRL_INVERT_BIT]),
                .burst_en(ctrl[g][`SMG_CTRL_BURST_BIT]),
                .sweep_en(ctrl[g][`SMG_CTRL_SWEEP_BIT]),
                .arb_sel(ctrl[g][`SMG_CTRL_ARB_BIT]),
                .seq_sel(ctrl[g][`SMG_CTRL_SEQ_BIT]),
                .fixed_frequency(ctrl[g][`SMG_CTRL_FIXED_BIT]),
                .mod_active(ctrl[g][`SMG_CTRL_MOD_BIT]),
                .carrier_sync_mode(!ctrl[g][`SMG_CTRL_MARKER_BIT]),
                .wr_cyc(wr && paddr == `SMG_CYC_OFS && chsel == g),
                .wr_freq(wr && paddr == `SMG_FREQ_OFS && chsel == g),
                .wr_point(wr && paddr == `SMG_POINT_OFS && chsel == g),
                .wdata(pwdata[W-1:0]),
                .burst_cycle_total(burst_cycle_total[g*W +: W]),
                .sweep_start(sweep_start[g*W +: W]),
                .sweep_stop(sweep_stop[g*W +: W]),
                .arb_length(arb_length[g*W +: W]),
                .start_evt(start_evt[g]),
                .cycle_count(cycle_count[g*W +: W]),
                .sweep_freq(sweep_freq[g*W +: W]),
                .sample_index(sample_index[g*W +: W]),
                .arb_new(arb_new[g]),
                .mark_cycle(ch_cyc[g*W +: W]),
                .mark_freq(ch_freq[g*W +: W]),
                .mark_point(ch_pt[g*W +: W]),
                .sync_out(ch_sync[g]),
                .conflict(ch_conf[g]),
                .reject(ch_rej[g])
            );
        end
    endgenerate

    // Read mux for the selected channel
    always @* begin
        next_rdata = 32'h00000000;
        case (paddr)
            `SMG_CTRL_OFS: next_rdata = {24'h000000, cur_ctrl};
            `SMG_STAT_OFS: next_rdata = {30'h00000000, stat};
            `SMG_MASK_OFS: next_rdata = {30'h00000000, mask};
            `SMG_CHSEL_OFS: next_rdata = {24'h000000, chsel};
            `SMG_CYC_OFS: next_rdata = ch_cyc[chsel[0]*W +: W];
            `SMG_FREQ_OFS: next_rdata = ch_freq[chsel[0]*W +: W];
            `SMG_POINT_OFS: next_rdata = ch_pt[chsel[0]*W +: W];
            default: next_rdata = 32'h00000000;
        endcase
    end

    // APB slave: one wait state, answer in second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            chsel <= 8'h00;
            mask <= 2'h0;
            stat <= 2'h0;
            irq <= 1'b0;
            sync_out <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                ctrl[i] <= 8'h00;
            end
        end else begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && (paddr > `SMG_POINT_OFS || paddr[1:0] != 2'h0);
            if (acc && !pready && !pwrite) begin
                prdata <= next_rdata;
            end
            if (wr && paddr == `SMG_CTRL_OFS) begin
                ctrl[chsel[0]] <= pwdata[7:0];
            end
            if (wr && paddr == `SMG_CHSEL_OFS) begin
                chsel <= (pwdata[7:0] < NCH) ? pwdata[7:0] : 8'h00;
            end
            if (wr && paddr == `SMG_MASK_OFS) begin
                mask <= pwdata[1:0];
            end
            // Hardware set wins over write-one clear
            if (wr && paddr == `SMG_STAT_OFS) begin
                stat <= (stat & ~pwdata[1:0]) | evt;
            end else begin
                stat <= stat | evt;
            end
            irq <= |(stat & mask);
            sync_out <= ch_sync;
        end
    end
endmodule // smg_top

/* File: test/smg_properties.sv */
// Watches the APB port and the sync pins of the top
module smg_properties #(
    parameter NCH = 2,
    parameter W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [NCH-1:0] start_evt,
    input wire [NCH-1:0] sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic chs;
    logic [7:0] c0;
    logic [7:0] c1;
    wire acc = psel && penable;
    // Marker mode alone: no compare may pull sync low
    wire idle0 = c0[0] && c0[4:1] == 4'h0;
    // Mirror of control writes, per selected channel
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chs <= 1'b0;
            c0 <= 8'h00;
            c1 <= 8'h00;
        end else if (acc && pwrite) begin
            if (paddr == 12'h00C) chs <= pwdata[0];
            if (paddr == 12'h000 && !chs) c0 <= pwdata[7:0];
            if (paddr == 12'h000 && chs) c1 <= pwdata[7:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (acc && !pready |=> pready)
        else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unaligned: assert property (acc && !pready && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned accepted");
    a_start_high: assert property (
        start_evt[0] && c0[0] && !c0[1] |-> ##2 sync_out[0]) else $error("sync not high");
    a_start_inverted: assert property (
        start_evt[0] && c0[0] && c0[1] |-> ##2 !sync_out[0]) else $error("sync not inverted");
    a_chan_one_start: assert property (
        start_evt[1] && c1[0] && !c1[1] |-> ##2 sync_out[1]) else $error("second sync");
    a_hold_no_compare: assert property (
        idle0 && $past(idle0, 3) && sync_out[0] |=> sync_out[0]) else $error("sync dropped");
    cover property (start_evt[0] && c0[2]);
    cover property (pslverr);
    cover property (sync_out[1]);
endmodule // smg_properties

/* File: test/smg_seq_model.sv */
// Burst, sweep and arb sequencer stand-in
module smg_seq_model #(
    parameter NCH = 2,
    parameter W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NCH-1:0] go,
    output logic [NCH-1:0] start_evt,
    output logic [NCH*W-1:0] cycle_count,
    output wire logic [NCH*W-1:0] sweep_freq,
    output wire logic [NCH*W-1:0] sample_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // One counter per channel; it halts at 255 so it stands still between runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_evt <= '0;
            cycle_count <= '0;
        end else begin
            start_evt <= go;
            for (int g = 0; g < NCH; g++) begin
                if (go[g]) cycle_count[g*W +: W] <= W'(1);
                else if (cycle_count[g*W +: W] < W'(255))
                    cycle_count[g*W +: W] <= cycle_count[g*W +: W] + W'(1);
            end
        end
    end
    // Swept frequency and sample index advance in step with the cycle count
    assign sweep_freq = cycle_count;
    assign sample_index = cycle_count;
endmodule // smg_seq_model

/* File: test/smg_top_bench.sv */
module smg_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 2;
    localparam int W = 32;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [NCH-1:0] go = '0, arb_new = '0, start_evt, sync_out;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [NCH*W-1:0] cycle_count, sweep_freq, sample_index;
    int n_mismatch = 0, tests_run = 0, w;
    always #2 pclk = ~pclk;
    smg_seq_model #(.NCH(NCH), .W(W)) i_smg_seq_model (.pclk(pclk), .presetn(presetn),
        .go(go), .start_evt(start_evt), .cycle_count(cycle_count),
        .sweep_freq(sweep_freq), .sample_index(sample_index));
    // Burst of 10, sweep 1 to 40, arb of 20 samples on both channels
    smg_top #(.NCH(NCH), .W(W)) i_smg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_evt(start_evt), .arb_new(arb_new),
        .cycle_count(cycle_count), .sweep_freq(sweep_freq), .sample_index(sample_index),
        .burst_cycle_total({2{32'hA}}), .sweep_start({2{32'h1}}), .sweep_stop({2{32'h28}}),
        .arb_length({2{32'h14}}), .sync_out(sync_out), .irq(irq));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; bounded wait on pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so two calls never drive psel twice in one step
        @(posedge pclk);
    endtask
    task automatic rdk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Count cycles of active sync level over a fixed window after a start
    task automatic run(input int ch, input logic inv);
        go[ch] <= 1'b1;
        @(posedge pclk);
        go[ch] <= 1'b0;
        w = 0;
        repeat (60) begin
            @(posedge pclk);
            if (sync_out[ch] === !inv) w++;
        end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdk(12'h010, 32'h2);
        rdk(12'h014, 32'h1F4);
        apb(1'b0, 12'h01C, 32'h0);
        chk(er, 1'b1);
        apb(1'b0, 12'h002, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, 12'h008, 32'h3);
        apb(1'b1, 12'h000, 32'h5);
        apb(1'b1, 12'h010, 32'hB);
        rdk(12'h010, 32'hB);
        apb(1'b1, 12'h010, 32'h5);
        run(0, 1'b0);
        chk(w, 4);
        apb(1'b1, 12'h010, 32'h14);
        rdk(12'h010, 32'h6);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(irq, 1'b1);
        apb(1'b1, 12'h004, 32'h3);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, 12'h000, 32'h7);
        run(0, 1'b1);
        chk(w, 5);
        apb(1'b1, 12'h000, 32'h9);
        apb(1'b1, 12'h014, 32'h7);
        run(0, 1'b0);
        chk(w, 6);
        apb(1'b1, 12'h014, 32'h64);
        rdk(12'h014, 32'h28);
        apb(1'b1, 12'h014, 32'h0);
        rdk(12'h014, 32'h1);
        apb(1'b1, 12'h000, 32'h51);
        arb_new[0] <= 1'b1;
        @(posedge pclk);
        arb_new[0] <= 1'b0;
        rdk(12'h018, 32'hA);
        run(0, 1'b0);
        chk(w, 9);
        apb(1'b1, 12'h018, 32'h12);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd & 32'h2, 32'h2);
        rdk(12'h018, 32'hA);
        apb(1'b1, 12'h018, 32'h11);
        rdk(12'h018, 32'h11);
        apb(1'b1, 12'h000, 32'h11);
        apb(1'b1, 12'h018, 32'h5);
        rdk(12'h018, 32'h11);
        apb(1'b1, 12'h000, 32'h14);
        apb(1'b1, 12'h018, 32'h5);
        rdk(12'h018, 32'h5);
        apb(1'b1, 12'h000, 32'h18);
        apb(1'b1, 12'h018, 32'h8);
        rdk(12'h018, 32'h8);
        apb(1'b1, 12'h000, 32'h91);
        apb(1'b1, 12'h018, 32'h6);
        rdk(12'h018, 32'h6);
        apb(1'b1, 12'h000, 32'h71);
        apb(1'b1, 12'h018, 32'h7);
        rdk(12'h018, 32'h6);
        apb(1'b1, 12'h000, 32'h1);
        run(0, 1'b0);
        chk(w > 50, 1'b1);
        apb(1'b1, 12'h00C, 32'h1);
        rdk(12'h010, 32'h2);
        apb(1'b1, 12'h000, 32'h5);
        run(1, 1'b0);
        chk(w, 1);
        complete_run();
    end
endmodule // smg_top_bench
bind smg_top smg_properties #(.NCH(NCH), .W(W)) i_smg_properties (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .start_evt(start_evt),
    .sync_out(sync_out));
